// [src/adc_control_registers.sv]
// converter control registers with AHB-Lite slave, start sequencing,
// busy flag and end-of-conversion interrupt.
// assumes an external conversion core answering with core_done.
// What this block does
// - conversion begins only after start bit goes high then low
// - start high resets converter and forces busy flag to one
// - busy flag bit 6 read-only; one while converting, zero after
// - control register bits 5 and 4 read as zero
// - four-bit channel code routes one of ten sources to converter
// - power bit 6 zero powers converter on, one powers it down
// - reference bit 5 zero internal supply, one external pin or regulator
// - three-bit clock code divides system clock by 2,8,32,1,4,16
// - clock/power register bit 7 reads as one
// - clock/power register bits 4 and 3 read as zero
// - pin enable bit one makes pin analog input for its channel
// - large variant pin enable bits 7 and 6 select channels 7, 6
// - conversion end clears busy flag and raises interrupt request
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module adc_control_registers
  import adc_ctrl_pkg::*;
#(
  parameter int PIN_COUNT = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic core_done,
  output core_ctrl_s core_ctrl,
  output logic converter_tick,
  output logic [7:0] analog_pin_enables,
  output logic irq
);
  if (PIN_COUNT != 6 && PIN_COUNT != 8) begin : g_bad_pins
    $error("PIN_COUNT must be 6 or 8");
  end

  localparam logic [7:0] PIN_MASK = (PIN_COUNT == 8) ? 8'hFF : 8'h3F;

  logic start_bit;
  logic busy;
  logic [3:0] channel_select;
  logic converter_power_off;
  logic reference_select;
  logic [2:0] converter_clock_divider;
  logic [7:0] pin_en;
  logic irq_status;
  logic irq_mask;
  logic conv_done_event;
  conv_state_e state;
  conv_state_e next_state;

  // bus address phase capture
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_go;
  logic [7:0] rd_addr;
  logic wr_go;
  logic [7:0] wdata;

  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_go = wr_pend;
  assign wdata = hwdata[7:0];
  assign rd_addr = haddr[7:0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // control register writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_bit <= 1'b0;
      channel_select <= CHAN_RST;
    end else if (wr_go && wr_addr == OFF_CONV_CTRL) begin
      start_bit <= wdata[START_BIT];
      channel_select <= wdata[CHAN_LSB +: 4];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      converter_power_off <= 1'b0;
      reference_select <= 1'b0;
      converter_clock_divider <= DIV_RST;
    end else if (wr_go && wr_addr == OFF_CLK_PWR) begin
      converter_power_off <= wdata[PWR_OFF_BIT];
      reference_select <= wdata[REF_SEL_BIT];
      converter_clock_divider <= wdata[DIV_LSB +: 3];
    end
  end

  // unimplemented pin bits held at zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_en <= PIN_EN_RST;
    end else if (wr_go && wr_addr == OFF_PIN_EN) begin
      pin_en <= wdata & PIN_MASK;
    end
  end

  // sequencer: hold while high, run on fall
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start_bit) next_state = ST_HOLD;
      ST_HOLD: if (!start_bit) next_state = ST_RUN;
      ST_RUN: begin
        if (start_bit) next_state = ST_HOLD;
        else if (core_done) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign conv_done_event = state == ST_RUN && !start_bit && core_done;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy <= BUSY_RST;
    end else if (start_bit) begin
      busy <= 1'b1;
    end else if (conv_done_event) begin
      busy <= 1'b0;
    end
  end

  // sticky interrupt, set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_status <= 1'b0;
    end else if (conv_done_event) begin
      irq_status <= 1'b1;
    end else if (wr_go && wr_addr == OFF_IRQ_STATUS && wdata[0]) begin
      irq_status <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_mask <= 1'b0;
    end else if (wr_go && wr_addr == OFF_IRQ_MASK) begin
      irq_mask <= wdata[0];
    end
  end

  assign irq = irq_status && irq_mask;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_ctrl <= '0;
      analog_pin_enables <= PIN_EN_RST;
    end else begin
      core_ctrl.power_off <= converter_power_off;
      core_ctrl.reference_select <= reference_select;
      core_ctrl.source_onehot <= (channel_select < 4'(NUM_SOURCES))
        ? NUM_SOURCES'(1) << channel_select : '0;
      core_ctrl.reset <= start_bit;
      core_ctrl.start <= state == ST_HOLD && !start_bit;
      analog_pin_enables <= pin_en;
    end
  end

  adc_clock_divider adc_clock_divider_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .div_code(converter_clock_divider),
    .run(!converter_power_off),
    .tick(converter_tick)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_go) begin
      unique case (rd_addr)
        OFF_CONV_CTRL: hrdata <= {24'h00_0000, start_bit, busy, 2'b00, channel_select};
        OFF_CLK_PWR: hrdata <= {24'h00_0000, 1'b1, converter_power_off,
          reference_select, 2'b00, converter_clock_divider};
        OFF_PIN_EN: hrdata <= {24'h00_0000, pin_en};
        OFF_IRQ_STATUS: hrdata <= {31'h0000_0000, irq_status};
        OFF_IRQ_MASK: hrdata <= {31'h0000_0000, irq_mask};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  sequence s_start_pulse;
    start_bit ##1 !start_bit;
  endsequence

  property p_start_after_fall;
    @(posedge clk) disable iff (sys_rst)
      s_start_pulse |-> ##1 core_ctrl.start;
  endproperty
  a_start_after_fall: assert property (p_start_after_fall) else $error("no start after fall");

  property p_no_start_high;
    @(posedge clk) disable iff (sys_rst)
      start_bit |-> ##1 !core_ctrl.start && core_ctrl.reset && busy;
  endproperty
  a_no_start_high: assert property (p_no_start_high) else $error("start while high");

  property p_busy_clear;
    @(posedge clk) disable iff (sys_rst)
      conv_done_event |=> !busy && irq_status;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("done not reflected");

  property p_busy_read;
    @(posedge clk) disable iff (sys_rst)
      rd_go && rd_addr == OFF_CONV_CTRL |=> hrdata[BUSY_BIT] == $past(busy)
        && hrdata[5:4] == 2'b00;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("control readback wrong");

  property p_clkpwr_read;
    @(posedge clk) disable iff (sys_rst)
      rd_go && rd_addr == OFF_CLK_PWR |=> hrdata[7] && hrdata[4:3] == 2'b00;
  endproperty
  a_clkpwr_read: assert property (p_clkpwr_read) else $error("fixed bits wrong");

  property p_source;
    @(posedge clk) disable iff (sys_rst)
      channel_select == 4'h9 && $stable(channel_select) |=> core_ctrl.source_onehot[9];
  endproperty
  a_source: assert property (p_source) else $error("source route wrong");

  property p_power;
    @(posedge clk) disable iff (sys_rst)
      converter_power_off ##1 converter_power_off |-> core_ctrl.power_off ##1 !converter_tick;
  endproperty
  a_power: assert property (p_power) else $error("power off not honoured");

  property p_ref;
    @(posedge clk) disable iff (sys_rst)
      1'b1 |=> core_ctrl.reference_select == $past(reference_select);
  endproperty
  a_ref: assert property (p_ref) else $error("reference not routed");

  property p_pins;
    @(posedge clk) disable iff (sys_rst)
      1'b1 |=> (analog_pin_enables & ~PIN_MASK) == 8'h00;
  endproperty
  a_pins: assert property (p_pins) else $error("unimplemented pin set");
endmodule : adc_control_registers
`default_nettype wire

// [inc/adc_ctrl_pkg.sv]
// package: register map, field positions, reset values, types for the
// converter control block. assumes a 32-bit AHB-Lite register bus.
package adc_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CONV_CTRL = 8'h00;
  localparam logic [7:0] OFF_CLK_PWR = 8'h04;
  localparam logic [7:0] OFF_PIN_EN = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  // conversion_control fields
  localparam int START_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int CHAN_LSB = 0;
  // converter_clock_power fields
  localparam int PWR_OFF_BIT = 6;
  localparam int REF_SEL_BIT = 5;
  localparam int DIV_LSB = 0;
  localparam int CLK_PWR_ONE_BIT = 7;
  // reset values
  localparam logic [3:0] CHAN_RST = 4'h0;
  localparam logic [2:0] DIV_RST = 3'h0;
  localparam logic [7:0] PIN_EN_RST = 8'h00;
  localparam logic BUSY_RST = 1'b1;
  // number of selectable sources
  localparam int NUM_SOURCES = 10;
  // divider codes
  localparam logic [2:0] DIV_CODE_2 = 3'h0;
  localparam logic [2:0] DIV_CODE_8 = 3'h1;
  localparam logic [2:0] DIV_CODE_32 = 3'h2;
  localparam logic [2:0] DIV_CODE_1 = 3'h4;
  localparam logic [2:0] DIV_CODE_4 = 3'h5;
  localparam logic [2:0] DIV_CODE_16 = 3'h6;
  // converter core handshake
  typedef struct packed {
    logic power_off;
    logic reference_select;
    logic [NUM_SOURCES-1:0] source_onehot;
    logic reset;
    logic start;
  } core_ctrl_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b100
  } conv_state_e;
endpackage : adc_ctrl_pkg

// [src/adc_clock_divider.sv]
// converter clock enable generator: one tick per divided period.
// assumes divider code is stable except at software writes.
`timescale 1ns/10ps
`default_nettype none
module adc_clock_divider
  import adc_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] div_code,
  input wire logic run,
  output logic tick
);
  logic [4:0] count;
  logic [4:0] limit;
  logic undefined_code;

  always_comb begin
    undefined_code = 1'b0;
    unique case (div_code)
      DIV_CODE_1: limit = 5'd0;
      DIV_CODE_2: limit = 5'd1;
      DIV_CODE_4: limit = 5'd3;
      DIV_CODE_8: limit = 5'd7;
      DIV_CODE_16: limit = 5'd15;
      DIV_CODE_32: limit = 5'd31;
      default: begin
        limit = 5'd31;
        undefined_code = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !run || count == limit) begin
      count <= 5'd0;
    end else begin
      count <= count + 5'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick <= 1'b0;
    end else begin
      tick <= run && !undefined_code && count == limit;
    end
  end

  property p_tick_period;
    @(posedge clk) disable iff (sys_rst)
      (run && div_code == DIV_CODE_2 && tick) ##1 (run && div_code == DIV_CODE_2)
        |=> tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("divide by 2 period wrong");
endmodule : adc_clock_divider
`default_nettype wire

// [test/adc_control_registers_tb.sv]
// testbench for the converter control registers: bus tasks, one task per scenario.
// assumes zero wait state slave; two instances share one bus (large and small variant).
`timescale 1ns/10ps
`default_nettype none
module adc_control_registers_tb
  import adc_ctrl_pkg::*;
;
  logic clk, sys_rst, hsel, hwrite, core_done;
  logic [31:0] haddr, hwdata, hrdata, hrdata_small, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, converter_tick, irq;
  logic [7:0] analog_pin_enables, pins_small;
  core_ctrl_s core_ctrl;
  int num_errors = 0;
  int checks = 0;

  adc_control_registers #(.PIN_COUNT(8)) adc_control_registers_inst (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .core_done(core_done),
    .core_ctrl(core_ctrl), .converter_tick(converter_tick),
    .analog_pin_enables(analog_pin_enables), .irq(irq));
  adc_control_registers #(.PIN_COUNT(6)) adc_control_registers_small_inst (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata_small), .hreadyout(), .hresp(), .core_done(core_done),
    .core_ctrl(), .converter_tick(), .analog_pin_enables(pins_small), .irq());

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1, "ready wait");
  endtask : wait_ready

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready;
    rd = hrdata;
  endtask : bus

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task t_reset;
    bus(1'b0, OFF_CONV_CTRL, 32'h0); chk(rd, 32'h0000_0040, "ctrl reset");
    bus(1'b0, OFF_CLK_PWR, 32'h0); chk(rd, 32'h0000_0080, "clkpwr reset");
    bus(1'b0, OFF_PIN_EN, 32'h0); chk(rd, 32'h0000_0000, "pins reset");
    bus(1'b0, 8'h14, 32'h0); chk(rd, 32'h0000_0000, "unmapped");
    chk({31'h0, hresp}, 32'h0, "resp okay");
    $display("test reset done");
  endtask : t_reset

  task t_fields;
    bus(1'b1, OFF_CONV_CTRL, 32'hFFFF_FFFF);
    bus(1'b0, OFF_CONV_CTRL, 32'h0); chk(rd, 32'h0000_00CF, "ctrl ones");
    chk({31'h0, core_ctrl.reset}, 32'h1, "core reset");
    bus(1'b1, OFF_CLK_PWR, 32'h0000_00FF);
    bus(1'b0, OFF_CLK_PWR, 32'h0); chk(rd, 32'h0000_00E7, "clkpwr ones");
    step(2);
    chk({30'h0, core_ctrl.power_off, core_ctrl.reference_select}, 32'h3, "pwr ref 1");
    bus(1'b1, OFF_CLK_PWR, 32'h0);
    bus(1'b0, OFF_CLK_PWR, 32'h0); chk(rd, 32'h0000_0080, "clkpwr zero");
    step(2);
    chk({30'h0, core_ctrl.power_off, core_ctrl.reference_select}, 32'h0, "pwr ref 0");
    bus(1'b1, OFF_PIN_EN, 32'h0000_00FF);
    bus(1'b0, OFF_PIN_EN, 32'h0); chk(rd, 32'h0000_00FF, "pins large");
    chk(hrdata_small, 32'h0000_003F, "pins small");
    step(2);
    chk({16'h0, analog_pin_enables, pins_small}, 32'h0000_FF3F, "pin outputs");
    $display("test fields done");
  endtask : t_fields

  task t_channels;
    logic [9:0] exp;
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, OFF_CONV_CTRL, c);
      step(2);
      exp = (c < NUM_SOURCES) ? (10'h001 << c) : 10'h000;
      chk({22'h0, core_ctrl.source_onehot}, {22'h0, exp}, "source");
    end
    $display("test channels done");
  endtask : t_channels

  task count_ticks(input int span, output int n);
    n = 0;
    repeat (span) begin
      step(1);
      if (converter_tick === 1'b1) n++;
    end
  endtask : count_ticks

  task count_starts(input int span, output int n);
    n = 0;
    repeat (span) begin
      step(1);
      if (core_ctrl.start === 1'b1) n++;
    end
  endtask : count_starts

  task t_divider;
    logic [2:0] codes [6];
    int divs [6];
    int n;
    codes = '{DIV_CODE_1, DIV_CODE_2, DIV_CODE_4, DIV_CODE_8, DIV_CODE_16, DIV_CODE_32};
    divs = '{1, 2, 4, 8, 16, 32};
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, OFF_CLK_PWR, {29'h0, codes[i]});
      step(40);
      count_ticks(divs[i] * 4, n);
      chk(n, 4, "ticks per span");
    end
    bus(1'b1, OFF_CLK_PWR, 32'h0000_0003); step(4); count_ticks(80, n);
    chk(n, 0, "code 011");
    bus(1'b1, OFF_CLK_PWR, 32'h0000_0007); step(4); count_ticks(80, n);
    chk(n, 0, "code 111");
    bus(1'b1, OFF_CLK_PWR, 32'h0000_0044); step(4); count_ticks(80, n);
    chk(n, 0, "powered off");
    bus(1'b1, OFF_CLK_PWR, {29'h0, DIV_CODE_32});
    $display("test divider done");
  endtask : t_divider

  task pulse_done;
    @(posedge clk);
    core_done <= 1'b1;
    @(posedge clk);
    core_done <= 1'b0;
  endtask : pulse_done

  task t_conversion;
    int n;
    bus(1'b1, OFF_IRQ_MASK, 32'h1);
    bus(1'b1, OFF_CONV_CTRL, 32'h0000_0083);
    bus(1'b0, OFF_CONV_CTRL, 32'h0); chk(rd, 32'h0000_00C3, "start high");
    count_starts(6, n); chk(n, 0, "no start while high");
    bus(1'b1, OFF_CONV_CTRL, 32'h0000_0003);
    count_starts(6, n);
    chk(n, 1, "one start pulse");
    chk({31'h0, core_ctrl.reset}, 32'h0, "core reset low");
    bus(1'b0, OFF_CONV_CTRL, 32'h0); chk(rd, 32'h0000_0043, "busy running");
    chk({31'h0, irq}, 32'h0, "no irq yet");
    pulse_done;
    bus(1'b0, OFF_CONV_CTRL, 32'h0); chk(rd, 32'h0000_0003, "busy cleared");
    bus(1'b1, OFF_CONV_CTRL, 32'h0000_0043);
    bus(1'b0, OFF_CONV_CTRL, 32'h0); chk(rd, 32'h0000_0003, "busy read only");
    bus(1'b0, OFF_IRQ_STATUS, 32'h0); chk(rd, 32'h1, "status set");
    chk({31'h0, irq}, 32'h1, "irq high");
    bus(1'b1, OFF_IRQ_MASK, 32'h0); step(1);
    chk({31'h0, irq}, 32'h0, "irq masked");
    bus(1'b1, OFF_IRQ_MASK, 32'h1);
    bus(1'b1, OFF_IRQ_STATUS, 32'h1);
    bus(1'b0, OFF_IRQ_STATUS, 32'h0); chk(rd, 32'h0, "status cleared");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    bus(1'b1, OFF_CONV_CTRL, 32'h0000_0080);
    bus(1'b1, OFF_CONV_CTRL, 32'h0);
    bus(1'b1, OFF_CONV_CTRL, 32'h0000_0080);
    pulse_done;
    bus(1'b0, OFF_IRQ_STATUS, 32'h0); chk(rd, 32'h0, "cancel no irq");
    bus(1'b0, OFF_CONV_CTRL, 32'h0); chk(rd, 32'h0000_00C0, "cancel busy");
    $display("test conversion done");
  endtask : t_conversion

  task final_report;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #200000;
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    final_report;
  end

  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    core_done = 1'b0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_fields;
    t_channels;
    t_divider;
    t_conversion;
    final_report;
  end
endmodule : adc_control_registers_tb
`default_nettype wire
